/* core/mac_cfg.svh */
// constants for the multiply-accumulate coprocessor datapath
// assumes a 32-bit apb slave port and 16-bit data addresses
`ifndef MAC_CFG_SVH
`define MAC_CFG_SVH
`define MAC_OFF_CTRL 8'h00
`define MAC_OFF_STATUS 8'h04
`define MAC_OFF_ACCH 8'h08
`define MAC_OFF_ACCL 8'h0c
`define MAC_OFF_INDEX_POINTER_0 8'h10
`define MAC_OFF_INDEX_POINTER_1 8'h14
`define MAC_OFF_QX0 8'h18
`define MAC_OFF_QX1 8'h1c
`define MAC_OFF_QR0 8'h20
`define MAC_OFF_QR1 8'h24
`define MAC_OFF_LIMIT 8'h28
`define CTRL_BIT_FRAC 9
`define CTRL_BIT_SAT 10
`define ST_BIT_N 8
`define ST_BIT_Z 9
`define ST_BIT_E 10
`define ST_BIT_SV 11
`define ST_BIT_C 12
`define ST_BIT_SL 13
`define PTR_STEP 16'h0002
`define RAM_BASE 16'hf600
`define RAM_MASK 16'h03ff
`define ROUND_CONST 40'h00_0000_8000
`define SAT_POS 40'h00_7fff_ffff
`define SAT_NEG 40'hff_8000_0000
`define LIM_POS 16'h7fff
`define LIM_NEG 16'h8000
`define SHIFT_MAX 4'h8
`endif

/* core/mac_pkg.sv */
// types shared by the coprocessor datapath and its bench
// assumes mac_cfg.svh for all numeric constants
package mac_pkg;
  typedef enum logic [3:0] {
    OP_NOP = 4'b0000, OP_MUL = 4'b0001, OP_MAC = 4'b0010, OP_MACM = 4'b0011,
    OP_MSUB = 4'b0100, OP_LOAD = 4'b0101, OP_ADD = 4'b0110, OP_RND = 4'b0111,
    OP_SHL = 4'b1000, OP_SHR = 4'b1001, OP_CLR = 4'b1010, OP_STORE = 4'b1011,
    OP_TCOPY = 4'b1100
  } op_e;
  typedef enum logic [2:0] {
    PM_NONE = 3'b000, PM_INC = 3'b001, PM_DEC = 3'b010, PM_ADDQ = 3'b011, PM_SUBQ = 3'b100
  } ptrmod_e;
  typedef enum logic [2:0] {
    SR_ACCH = 3'b000, SR_ACCL = 3'b001, SR_STATUS = 3'b010, SR_CTRL = 3'b011,
    SR_LIMIT = 3'b100
  } storesel_e;
  typedef struct packed {
    op_e op;
    logic idxSel;
    ptrmod_e idxMod;
    logic idxOffSel;
    ptrmod_e gprMod;
    logic gprOffSel;
    logic [3:0] gprNum;
    logic signA;
    logic signB;
    logic catShift;
    logic [3:0] shiftAmt;
    storesel_e storeSel;
  } instr_s;
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [15:0] data;
  } memreq_s;
endpackage

/* core/mac_coprocessor_datapath.sv */
// multiply-accumulate coprocessor datapath: pipeline, address generation,
// multiplier, 40-bit arithmetic unit, limiter and shifter, apb registers.
// assumes the host cpu issues decoded instructions and returns operands
// on the two operand buses in the cycle after issue.
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "mac_cfg.svh"

// Summary of operation
// - three stages; decode computes addresses and post-modifies pointers
// - execute computes, updates accumulator and flags; gpr pointer written back
// - writeback stage only stores the parallel-moved operand
// - fast store reads coprocessor registers right after a mac
// - gpr pointer uses gpr offsets, index pointer uses index offsets
// - gpr addresses full space; index addresses confined to ram except table copy
// - index pointer: none, +2, -2, +offset, -offset; any offset with any pointer
// - gpr pointer 0..15: none, +2, -2, +/- gpr offset 0 or 1
// - parallel move for mac-with-move and table copy; index operand copied alongside
// - move address reverses the index post-modification on updated pointer
// - 16x16 signed/unsigned multiply, 32-bit product sign-extended to scaler
// - fractional shift bit shifts product left by one
// - extension flag set when top eight bits carry significant bits
// - adder a: zero, round constant, product, or shifted bus concatenation
// - adder b: accumulator shifted/inverted or zero
// - auto-saturate clamps 32-bit overflow and sets sticky limit flag
// - 40-bit overflow sets sticky overflow flag until software clears it
// - accumulator is high word, low word and extension byte in status
// - limiter outputs 7fffh or 8000h by sign when extension flag set
// - limiting leaves accumulator and status untouched
// - shifter: none, left or right up to 8; left shifts update flags
// - rounding adds one at bit 15 then clears the low word
module mac_coprocessor_datapath (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic issueValid,
  input wire mac_pkg::instr_s issueInstr,
  input wire logic [15:0] gprValue,
  input wire logic [15:0] operandBusA,
  input wire logic [15:0] operandBusB,
  output logic opAddrValid,
  output logic [15:0] opAddrGpr,
  output logic [15:0] opAddrIdx,
  output mac_pkg::memreq_s gprWrite,
  output mac_pkg::memreq_s moveWrite,
  output mac_pkg::memreq_s storeOut
);
  logic [15:0] ctrl_q;
  logic [15:0] accHigh_q;
  logic [15:0] accLow_q;
  logic [15:0] status_q;
  logic [15:0] idx_q [2];
  logic [15:0] qx_q [2];
  logic [15:0] qr_q [2];
  logic exValid_q;
  mac_pkg::instr_s exInstr_q;
  logic [15:0] gprNext_q;
  logic [15:0] moveAddr_q;
  logic wbValid_q;
  logic [15:0] wbAddr_q;
  logic [15:0] wbData_q;

  wire logic [39:0] acc = {status_q[7:0], accHigh_q, accLow_q};
  wire logic apbAccess = psel && penable && !pready;
  // write commits on the pready edge, when the master samples the answer
  wire logic apbWr = psel && penable && pready && pwrite;

  // ---------------- decode: address generation
  function automatic logic [15:0] postMod(input logic [15:0] p, input mac_pkg::ptrmod_e m,
                                          input logic [15:0] off);
    unique case (m)
      mac_pkg::PM_NONE: postMod = p;
      mac_pkg::PM_INC: postMod = p + `PTR_STEP;
      mac_pkg::PM_DEC: postMod = p - `PTR_STEP;
      mac_pkg::PM_ADDQ: postMod = p + off;
      mac_pkg::PM_SUBQ: postMod = p - off;
      default: postMod = p;
    endcase
  endfunction

  function automatic mac_pkg::ptrmod_e reverseMod(input mac_pkg::ptrmod_e m);
    unique case (m)
      mac_pkg::PM_INC: reverseMod = mac_pkg::PM_DEC;
      mac_pkg::PM_DEC: reverseMod = mac_pkg::PM_INC;
      mac_pkg::PM_ADDQ: reverseMod = mac_pkg::PM_SUBQ;
      mac_pkg::PM_SUBQ: reverseMod = mac_pkg::PM_ADDQ;
      default: reverseMod = mac_pkg::PM_NONE;
    endcase
  endfunction

  logic [15:0] idxCur;
  logic [15:0] idxOff;
  logic [15:0] idxNew;
  logic [15:0] gprOff;
  logic [15:0] idxAddr;
  always_comb begin
    idxCur = idx_q[issueInstr.idxSel];
    idxOff = qx_q[issueInstr.idxOffSel];
    gprOff = qr_q[issueInstr.gprOffSel];
    idxNew = postMod(idxCur, issueInstr.idxMod, idxOff);
    // index address wraps inside the dual-port ram window except for table copy
    if (issueInstr.op == mac_pkg::OP_TCOPY) begin
      idxAddr = idxCur;
    end else begin
      idxAddr = `RAM_BASE | (idxCur & `RAM_MASK);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      opAddrValid <= 1'b0;
      opAddrGpr <= 16'h0000;
      opAddrIdx <= 16'h0000;
      exValid_q <= 1'b0;
      exInstr_q <= '0;
      gprNext_q <= 16'h0000;
      moveAddr_q <= 16'h0000;
    end else begin
      opAddrValid <= issueValid;
      exValid_q <= issueValid;
      if (issueValid) begin
        opAddrGpr <= gprValue;
        opAddrIdx <= idxAddr;
        exInstr_q <= issueInstr;
        gprNext_q <= postMod(gprValue, issueInstr.gprMod, gprOff);
        moveAddr_q <= postMod(idxNew, reverseMod(issueInstr.idxMod), idxOff);
      end
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (sys_rst) begin
        idx_q[i] <= 16'h0000;
      end else if (issueValid && issueInstr.idxSel == 1'(i)) begin
        idx_q[i] <= idxNew;
      end else if (apbWr && paddr == (i == 0 ? `MAC_OFF_INDEX_POINTER_0 : `MAC_OFF_INDEX_POINTER_1)) begin
        idx_q[i] <= pwdata[15:0];
      end
    end
  end

  // ---------------- execute: multiplier, scaler, adder, shifter
  logic signed [16:0] mulA;
  logic signed [16:0] mulB;
  logic signed [33:0] prod;
  logic [39:0] prodExt;
  logic [39:0] catExt;
  logic [39:0] aIn;
  logic [39:0] bIn;
  logic cin;
  logic [40:0] usum;
  logic [39:0] shAcc;
  logic [39:0] topBits;
  logic [5:0] shN;
  logic shOvf40;
  logic shCarry;
  logic [39:0] res;
  logic ovf32;
  logic ovf40;
  logic resNeg;
  logic carry;
  logic writesAcc;
  logic isShl;
  always_comb begin
    mulA = {exInstr_q.signA & operandBusA[15], operandBusA};
    mulB = {exInstr_q.signB & operandBusB[15], operandBusB};
    prod = mulA * mulB;
    prodExt = {{6{prod[33]}}, prod};
    if (ctrl_q[`CTRL_BIT_FRAC]) begin
      prodExt = {prodExt[38:0], 1'b0};
    end
    catExt = {{8{operandBusA[15]}}, operandBusA, operandBusB};
    if (exInstr_q.catShift) begin
      catExt = {catExt[38:0], 1'b0};
    end
    shN = (exInstr_q.shiftAmt > `SHIFT_MAX) ? {2'b00, `SHIFT_MAX} : {2'b00, exInstr_q.shiftAmt};
    isShl = exInstr_q.op == mac_pkg::OP_SHL;
    topBits = 40'($signed(acc) >>> (6'd39 - shN));
    shOvf40 = isShl && !(topBits == 40'h00_0000_0000 || topBits == '1);
    shCarry = isShl && shN != 6'd0 && acc[6'd40 - shN];
    unique case (exInstr_q.op)
      mac_pkg::OP_SHL: shAcc = acc << shN;
      mac_pkg::OP_SHR: shAcc = 40'($signed(acc) >>> shN);
      default: shAcc = acc;
    endcase
    aIn = 40'h00_0000_0000;
    bIn = 40'h00_0000_0000;
    cin = 1'b0;
    writesAcc = 1'b1;
    unique case (exInstr_q.op)
      mac_pkg::OP_MUL: aIn = prodExt;
      mac_pkg::OP_MAC, mac_pkg::OP_MACM: begin
        aIn = prodExt;
        bIn = acc;
      end
      mac_pkg::OP_MSUB: begin
        aIn = prodExt;
        bIn = ~acc;
        cin = 1'b1;
      end
      mac_pkg::OP_LOAD: aIn = catExt;
      mac_pkg::OP_ADD: begin
        aIn = catExt;
        bIn = acc;
      end
      mac_pkg::OP_RND: begin
        aIn = `ROUND_CONST;
        bIn = acc;
      end
      mac_pkg::OP_SHL, mac_pkg::OP_SHR: bIn = shAcc;
      mac_pkg::OP_CLR: bIn = 40'h00_0000_0000;
      default: writesAcc = 1'b0;
    endcase
    usum = {1'b0, aIn} + {1'b0, bIn} + {40'h00_0000_0000, cin};
    res = usum[39:0];
    resNeg = aIn[39] ^ bIn[39] ^ usum[40];
    ovf40 = (resNeg != res[39]) || shOvf40;
    ovf32 = ovf40 || !(res[39:31] == 9'h000 || res[39:31] == 9'h1ff);
    carry = isShl ? shCarry : usum[40];
    if (isShl) begin
      resNeg = acc[39];
    end
    if (exInstr_q.op == mac_pkg::OP_RND) begin
      res[15:0] = 16'h0000;
    end
    // without auto-saturate the raw 40-bit value stands
    if (ctrl_q[`CTRL_BIT_SAT] && ovf32) begin
      res = resNeg ? `SAT_NEG : `SAT_POS;
    end
  end

  wire logic execAcc = exValid_q && writesAcc;
  wire logic satHit = execAcc && ctrl_q[`CTRL_BIT_SAT] && ovf32;
  wire logic extSig = !(res[39:31] == 9'h000 || res[39:31] == 9'h1ff);

  // ---------------- accumulator and status, updated at end of execute
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      accHigh_q <= 16'h0000;
      accLow_q <= 16'h0000;
    end else if (execAcc) begin
      accHigh_q <= res[31:16];
      accLow_q <= res[15:0];
    end else if (apbWr && paddr == `MAC_OFF_ACCH) begin
      accHigh_q <= pwdata[15:0];
    end else if (apbWr && paddr == `MAC_OFF_ACCL) begin
      accLow_q <= pwdata[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_q <= 16'h0000;
    end else begin
      if (apbWr && paddr == `MAC_OFF_STATUS) begin
        status_q <= pwdata[15:0];
      end
      if (execAcc) begin
        status_q[7:0] <= res[39:32];
        status_q[`ST_BIT_E] <= extSig;
        status_q[`ST_BIT_N] <= res[39];
        status_q[`ST_BIT_Z] <= res == 40'h00_0000_0000;
        status_q[`ST_BIT_C] <= carry;
      end
      // sticky flags: a hardware set beats a same-cycle software clear
      if (execAcc && ovf40) begin
        status_q[`ST_BIT_SV] <= 1'b1;
      end
      if (satHit) begin
        status_q[`ST_BIT_SL] <= 1'b1;
      end
    end
  end

  // limiter only looks at state, never writes it back
  logic [15:0] limited;
  always_comb begin
    if (!status_q[`ST_BIT_E]) begin
      limited = accHigh_q;
    end else if (status_q[`ST_BIT_N]) begin
      limited = `LIM_NEG;
    end else begin
      limited = `LIM_POS;
    end
  end

  // ---------------- execute side outputs and writeback stage
  logic [15:0] storeVal;
  always_comb begin
    unique case (exInstr_q.storeSel)
      mac_pkg::SR_ACCH: storeVal = accHigh_q;
      mac_pkg::SR_ACCL: storeVal = accLow_q;
      mac_pkg::SR_STATUS: storeVal = status_q;
      mac_pkg::SR_CTRL: storeVal = ctrl_q;
      mac_pkg::SR_LIMIT: storeVal = limited;
      default: storeVal = 16'h0000;
    endcase
  end

  wire logic isMove = exInstr_q.op == mac_pkg::OP_MACM || exInstr_q.op == mac_pkg::OP_TCOPY;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gprWrite <= '0;
      storeOut <= '0;
      wbValid_q <= 1'b0;
      wbAddr_q <= 16'h0000;
      wbData_q <= 16'h0000;
      moveWrite <= '0;
    end else begin
      gprWrite.valid <= exValid_q && exInstr_q.gprMod != mac_pkg::PM_NONE;
      gprWrite.addr <= {12'h000, exInstr_q.gprNum};
      gprWrite.data <= gprNext_q;
      // reads the accumulator left by the previous execute, so no gap needed
      storeOut.valid <= exValid_q && exInstr_q.op == mac_pkg::OP_STORE;
      storeOut.addr <= {13'h0000, exInstr_q.storeSel};
      storeOut.data <= storeVal;
      wbValid_q <= exValid_q && isMove;
      wbAddr_q <= moveAddr_q;
      wbData_q <= operandBusB;
      moveWrite.valid <= wbValid_q;
      moveWrite.addr <= wbAddr_q;
      moveWrite.data <= wbData_q;
    end
  end

  // ---------------- apb slave, one wait state per access
  logic mapped;
  logic [15:0] rdVal;
  always_comb begin
    mapped = 1'b1;
    unique case (paddr)
      `MAC_OFF_CTRL: rdVal = ctrl_q;
      `MAC_OFF_STATUS: rdVal = status_q;
      `MAC_OFF_ACCH: rdVal = accHigh_q;
      `MAC_OFF_ACCL: rdVal = accLow_q;
      `MAC_OFF_INDEX_POINTER_0: rdVal = idx_q[0];
      `MAC_OFF_INDEX_POINTER_1: rdVal = idx_q[1];
      `MAC_OFF_QX0: rdVal = qx_q[0];
      `MAC_OFF_QX1: rdVal = qx_q[1];
      `MAC_OFF_QR0: rdVal = qr_q[0];
      `MAC_OFF_QR1: rdVal = qr_q[1];
      `MAC_OFF_LIMIT: rdVal = limited;
      default: begin
        rdVal = 16'h0000;
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apbAccess;
      pslverr <= apbAccess && !mapped;
      prdata <= (apbAccess && !pwrite) ? {16'h0000, rdVal} : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q <= 16'h0000;
      qx_q[0] <= 16'h0000;
      qx_q[1] <= 16'h0000;
      qr_q[0] <= 16'h0000;
      qr_q[1] <= 16'h0000;
    end else if (apbWr) begin
      unique case (paddr)
        `MAC_OFF_CTRL: ctrl_q <= pwdata[15:0];
        `MAC_OFF_QX0: qx_q[0] <= pwdata[15:0];
        `MAC_OFF_QX1: qx_q[1] <= pwdata[15:0];
        `MAC_OFF_QR0: qr_q[0] <= pwdata[15:0];
        `MAC_OFF_QR1: qr_q[1] <= pwdata[15:0];
        default: ;
      endcase
    end
  end
endmodule

/* test/host_model.sv */
// host pipeline stand-in: latches operands at issue, drives them in execute
// assumes the bench presents reqA/reqB in the same cycle as issueValid
`timescale 1ns/1ps
module host_model (
  input logic clk,
  input logic issueValid,
  input logic [15:0] reqA,
  input logic [15:0] reqB,
  input logic opAddrValid,
  output logic [15:0] operandBusA,
  output logic [15:0] operandBusB
);
  logic [15:0] opA_q;
  logic [15:0] opB_q;

  // operands fetched in decode, offered only in the execute cycle
  always @(posedge clk) begin
    if (issueValid) begin
      opA_q <= reqA;
      opB_q <= reqB;
    end
  end
  // released buses show the inverse so stale data never passes for a match
  assign operandBusA = opAddrValid ? opA_q : ~opA_q;
  assign operandBusB = opAddrValid ? opB_q : ~opB_q;
endmodule

/* test/mac_monitor.sv */
// concurrent checks on the coprocessor datapath ports
// assumes a bind onto mac_coprocessor_datapath, one clock domain
`timescale 1ns/1ps
`include "mac_cfg.svh"
module mac_monitor (
  input logic clk,
  input logic sys_rst,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic issueValid,
  input mac_pkg::instr_s issueInstr,
  input logic [15:0] gprValue,
  input logic opAddrValid,
  input logic [15:0] opAddrIdx,
  input mac_pkg::memreq_s gprWrite,
  input mac_pkg::memreq_s moveWrite,
  input mac_pkg::memreq_s storeOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb access not answered after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_decode_addr: assert property (issueValid |=> opAddrValid)
    else $error("operand addresses missing after issue");
  a_idx_window: assert property (
    opAddrValid && $past(issueValid) && $past(issueInstr.op) != mac_pkg::OP_TCOPY
    |-> (opAddrIdx | `RAM_MASK) == (`RAM_BASE | `RAM_MASK))
    else $error("index address outside the ram window");
  a_gpr_inc: assert property (
    issueValid && issueInstr.gprMod == mac_pkg::PM_INC |-> ##2 gprWrite.valid
    && gprWrite.data == $past(gprValue, 2) + `PTR_STEP
    && gprWrite.addr == {12'h000, $past(issueInstr.gprNum, 2)})
    else $error("gpr pointer write-back wrong");
  a_gpr_cause: assert property (
    gprWrite.valid |-> $past(issueValid, 2) && $past(issueInstr.gprMod, 2) != mac_pkg::PM_NONE)
    else $error("gpr write-back without a modifying issue");
  a_move_cause: assert property (
    moveWrite.valid |-> $past(issueValid, 3)
    && $past(issueInstr.op, 3) inside {mac_pkg::OP_MACM, mac_pkg::OP_TCOPY})
    else $error("move write without a move instruction");
  a_move_lat: assert property (
    issueValid && issueInstr.op == mac_pkg::OP_MACM |-> ##3 moveWrite.valid)
    else $error("move write missing in writeback");
  a_store_lat: assert property (
    issueValid && issueInstr.op == mac_pkg::OP_STORE |-> ##2 storeOut.valid)
    else $error("store result missing");
endmodule

bind mac_coprocessor_datapath mac_monitor mon (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .issueValid(issueValid),
  .issueInstr(issueInstr), .gprValue(gprValue), .opAddrValid(opAddrValid),
  .opAddrIdx(opAddrIdx), .gprWrite(gprWrite), .moveWrite(moveWrite), .storeOut(storeOut));

/* test/tb.sv */
// self-checking bench: apb master, issue driver and integer accumulator model
// assumes the host model supplies operands in the execute cycle
`timescale 1ns/1ps
`include "mac_cfg.svh"
module tb;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, issueValid, opAddrValid, e;
  logic frac, sat, sl, sv, cy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] gprValue, operandBusA, operandBusB, reqA, reqB, opAddrGpr, opAddrIdx;
  logic [15:0] gSeen, iSeen, a, b, base;
  mac_pkg::instr_s issueInstr, ins;
  mac_pkg::memreq_s gprWrite, moveWrite, storeOut, gw, mw, so;
  mac_pkg::op_e ops[8] = '{mac_pkg::OP_LOAD, mac_pkg::OP_MUL, mac_pkg::OP_MAC,
    mac_pkg::OP_MSUB, mac_pkg::OP_ADD, mac_pkg::OP_SHL, mac_pkg::OP_SHR, mac_pkg::OP_RND};
  mac_pkg::ptrmod_e mods[5] = '{mac_pkg::PM_INC, mac_pkg::PM_DEC, mac_pkg::PM_ADDQ,
    mac_pkg::PM_SUBQ, mac_pkg::PM_INC};
  logic [15:0] di[5] = '{16'h0002, 16'hfffe, 16'h0006, 16'hfffa, 16'h0002};
  logic [15:0] dg[5] = '{16'h0002, 16'hfffe, 16'h0004, 16'hfffc, 16'h0000};
  int err_count, checks, seed;
  longint acc;

  mac_coprocessor_datapath dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .issueValid(issueValid), .issueInstr(issueInstr),
    .gprValue(gprValue), .operandBusA(operandBusA), .operandBusB(operandBusB),
    .opAddrValid(opAddrValid), .opAddrGpr(opAddrGpr), .opAddrIdx(opAddrIdx),
    .gprWrite(gprWrite), .moveWrite(moveWrite), .storeOut(storeOut));
  host_model host (.clk(clk), .issueValid(issueValid), .reqA(reqA), .reqB(reqB),
    .opAddrValid(opAddrValid), .operandBusA(operandBusA), .operandBusB(operandBusB));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d,
    output logic [31:0] r, output logic er);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // only the watchdog ends a wait for pready
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic setctl(input logic f, input logic s);
    frac = f;
    sat = s;
    apb(1'b1, `MAC_OFF_CTRL, {21'h0, s, f, 9'h0}, rd, e);
  endtask

  // keep leaves issueValid high so the next issue follows back to back
  task automatic issue(input mac_pkg::instr_s i, input logic [15:0] x, y, g, input bit keep);
    issueValid <= 1'b1; issueInstr <= i; reqA <= x; reqB <= y; gprValue <= g;
    @(posedge clk);
    if (!keep) begin
      issueValid <= 1'b0;
      gw = '0; mw = '0; so = '0;
      repeat (4) begin
        @(posedge clk);
        if (opAddrValid === 1'b1) begin
          gSeen = opAddrGpr;
          iSeen = opAddrIdx;
        end
        if (gprWrite.valid === 1'b1) gw = gprWrite;
        if (moveWrite.valid === 1'b1) mw = moveWrite;
        if (storeOut.valid === 1'b1) so = storeOut;
      end
    end
  endtask

  function automatic logic eflag();
    return acc[39:31] != {9{acc[39]}};
  endfunction

  function automatic void mdl(mac_pkg::instr_s i, logic [15:0] x, y);
    longint p, r, q;
    logic [40:0] cs;
    p = i.signA ? longint'($signed(x)) : longint'(x);
    p = p * (i.signB ? longint'($signed(y)) : longint'(y));
    p = frac ? p * 2 : p;
    q = longint'($signed({x, y}));
    q = i.catShift ? q * 2 : q;
    cs = '0;
    case (i.op)
      mac_pkg::OP_MUL: r = p;
      mac_pkg::OP_MAC, mac_pkg::OP_MACM: begin
        r = acc + p;
        cs = {1'b0, p[39:0]} + {1'b0, acc[39:0]};
      end
      mac_pkg::OP_MSUB: begin
        r = p - acc;
        cs = {1'b0, p[39:0]} + {1'b0, ~acc[39:0]} + 41'h1;
      end
      mac_pkg::OP_LOAD: r = q;
      mac_pkg::OP_ADD: begin
        r = acc + q;
        cs = {1'b0, q[39:0]} + {1'b0, acc[39:0]};
      end
      mac_pkg::OP_RND: begin
        r = (acc + 64'sh8000) & ~64'shffff;
        cs = {1'b0, acc[39:0]} + 41'h8000;
      end
      mac_pkg::OP_SHL: begin
        r = acc <<< i.shiftAmt;
        // carry is the last bit shifted out
        cs[40] = i.shiftAmt != 4'h0 && acc[40 - i.shiftAmt];
      end
      mac_pkg::OP_SHR: r = acc >>> i.shiftAmt;
      mac_pkg::OP_CLR: r = 0;
      default: r = acc;
    endcase
    cy = cs[40];
    if (r > 64'sh7f_ffff_ffff || r < -64'sh80_0000_0000) sv = 1'b1;
    if (sat && (r > 64'sh7fff_ffff || r < -64'sh8000_0000)) begin
      r = (r > 0) ? 64'sh7fff_ffff : -64'sh8000_0000;
      sl = 1'b1;
    end
    acc = longint'($signed(r[39:0]));
  endfunction

  task automatic chkacc();
    logic [31:0] h, l, s;
    repeat (2) @(posedge clk);
    apb(1'b0, `MAC_OFF_ACCH, 32'h0, h, e);
    apb(1'b0, `MAC_OFF_ACCL, 32'h0, l, e);
    apb(1'b0, `MAC_OFF_STATUS, 32'h0, s, e);
    chk("acc", acc[39:0], {s[7:0], h[15:0], l[15:0]});
    chk("status", {24'h0, 2'b00, sl, cy, sv, eflag(), acc == 0, acc[39], acc[39:32]},
      {24'h0, s[15:0]});
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    seed = $urandom(20856);
    sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; issueValid = 1'b0; issueInstr = '0; gprValue = 16'h0;
    reqA = 16'h0; reqB = 16'h0; err_count = 0; checks = 0; acc = 0;
    sl = 1'b0; sv = 1'b0; frac = 1'b0; sat = 1'b0;
    cy = 1'b0;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, `MAC_OFF_CTRL, 32'h0, rd, e);
    chk("ctrl reset", 40'h0, 40'(rd));
    a = 16'($urandom);
    apb(1'b1, `MAC_OFF_QX0, {16'h0, a}, rd, e);
    apb(1'b0, `MAC_OFF_QX0, 32'h0, rd, e);
    chk("qx0", 40'(a), 40'(rd));
    apb(1'b0, 8'h2c, 32'h0, rd, e);
    chk("unmapped", 40'h01_0000_0000, {7'h0, e, rd});
    ins = '0;
    ins.op = mac_pkg::OP_CLR;
    issue(ins, 16'h0, 16'h0, 16'h0, 1'b0);
    mdl(ins, 16'h0, 16'h0);
    for (int k = 0; k < 16; k++) begin
      setctl(1'($urandom), 1'b0);
      ins = '0;
      ins.op = ops[k % 8];
      ins.signA = 1'($urandom);
      ins.signB = 1'($urandom);
      ins.catShift = 1'($urandom);
      ins.shiftAmt = 4'($urandom_range(8));
      a = 16'($urandom);
      b = 16'($urandom);
      issue(ins, a, b, 16'h0, 1'b0);
      mdl(ins, a, b);
      chkacc();
    end
    for (int c = 0; c < 4; c++) begin
      setctl(1'b0, c < 2);
      ins = '0;
      ins.op = mac_pkg::OP_LOAD;
      issue(ins, c[0] ? 16'h8000 : 16'h7fff, c[0] ? 16'h0000 : 16'hffff, 16'h0, 1'b0);
      mdl(ins, c[0] ? 16'h8000 : 16'h7fff, c[0] ? 16'h0000 : 16'hffff);
      ins.op = mac_pkg::OP_ADD;
      issue(ins, c[0] ? 16'hffff : 16'h0000, c[0] ? 16'hffff : 16'h0001, 16'h0, 1'b0);
      mdl(ins, c[0] ? 16'hffff : 16'h0000, c[0] ? 16'hffff : 16'h0001);
      chkacc();
      ins.op = mac_pkg::OP_STORE;
      ins.storeSel = mac_pkg::SR_LIMIT;
      issue(ins, 16'h0, 16'h0, 16'h0, 1'b0);
      chk("limit", 40'(eflag() ? (acc[39] ? `LIM_NEG : `LIM_POS) : acc[31:16]),
        40'(so.data));
      chkacc();
    end
    ins = '0;
    ins.op = mac_pkg::OP_LOAD;
    issue(ins, 16'h1234, 16'h0042, 16'h0, 1'b0);
    mdl(ins, 16'h1234, 16'h0042);
    apb(1'b1, `MAC_OFF_STATUS, 32'h0, rd, e);
    // a status write clears every sticky and carry flag
    sl = 1'b0;
    sv = 1'b0;
    cy = 1'b0;
    chkacc();
    ins.op = mac_pkg::OP_MAC;
    issue(ins, 16'h0300, 16'h0101, 16'h0, 1'b1);
    mdl(ins, 16'h0300, 16'h0101);
    ins.op = mac_pkg::OP_STORE;
    ins.storeSel = mac_pkg::SR_ACCH;
    issue(ins, 16'h0, 16'h0, 16'h0, 1'b0);
    chk("fast store", 40'(acc[31:16]), 40'(so.data));
    apb(1'b1, `MAC_OFF_QX0, 32'h6, rd, e);
    apb(1'b1, `MAC_OFF_QX1, 32'h6, rd, e);
    apb(1'b1, `MAC_OFF_QR0, 32'h4, rd, e);
    apb(1'b1, `MAC_OFF_QR1, 32'h4, rd, e);
    for (int k = 0; k < 5; k++) begin
      base = (k == 4) ? 16'h0040 : 16'hf700;
      apb(1'b1, k[0] ? `MAC_OFF_INDEX_POINTER_1 : `MAC_OFF_INDEX_POINTER_0, {16'h0, base}, rd, e);
      ins = '0;
      ins.op = (k == 4) ? mac_pkg::OP_TCOPY : mac_pkg::OP_MACM;
      ins.idxSel = k[0];
      ins.idxOffSel = !k[0];
      ins.idxMod = mods[k];
      ins.gprMod = (k == 4) ? mac_pkg::PM_NONE : mods[k];
      ins.gprOffSel = k[0];
      ins.gprNum = 4'(k + 3);
      a = 16'($urandom);
      b = 16'($urandom);
      issue(ins, a, b, 16'h1000, 1'b0);
      if (k < 4) mdl(ins, a, b);
      chk("idx addr", 40'(base), 40'(iSeen));
      chk("gpr addr", 40'h1000, 40'(gSeen));
      chk("move", {7'h0, 1'b1, base, b}, {7'h0, mw.valid, mw.addr, mw.data});
      chk("gpr wb", (k == 4) ? 40'h0 : {7'h0, 1'b1, 12'h0, 4'(k + 3), 16'h1000 + dg[k]},
        {7'h0, gw.valid, gw.addr, gw.data});
      apb(1'b0, k[0] ? `MAC_OFF_INDEX_POINTER_1 : `MAC_OFF_INDEX_POINTER_0, 32'h0, rd, e);
      chk("idx ptr", 40'(16'(base + di[k])), 40'(rd[15:0]));
    end
    chkacc();
    summarize();
  end
endmodule
